// ===== design/lcd_level_comparator_delay.sv
/*
 * Four analogue level comparators (hysteresis or window) and four digital
 * comparators, each followed by an assert and a release delay, evaluated
 * on a periodic update tick, with routing to relay and virtual outputs.
 * Assumes synchronous inputs, one 125 MHz clock and an APB master.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ns

// Behaviour
// - hysteresis: rising above upper sets output
// - hysteresis: falling below lower clears output
// - hysteresis: otherwise output keeps previous state
// - window: inside band drives output high
// - window: outside band drives output low
// - type code 0 hysteresis default, 1 window
// - upper threshold settable, default 30.0
// - lower threshold settable, default 20.0
// - analogue assert delay, tenths, default zero
// - analogue release delay, same range, default zero
// - analogue delay timer readable as h:m:s.t
// - four identical independent analogue comparators
// - digital output follows selected status input
// - digital assert delay, default zero
// - digital release delay, default zero
// - digital delay timer readable as h:m:s.t
// - outputs selectable for relays and virtual routing
// - comparator and delay logic re-evaluated every 8 ms tick; bus and routing every clock
// - inverted analogue output always complements true output
// - lower above upper latches output once set
module lcd_level_comparator_delay #(
	parameter int TICK_CYCLES = lcd_pkg::TICK_CYCLES
) (
	input  wire logic                                 mclk,                    // System clock
	input  wire logic                                 rst_n,                   // Async reset
	input  wire logic                                 psel,                    // APB select
	input  wire logic                                 penable,                 // APB enable
	input  wire logic                                 pwrite,                  // APB write
	input  wire logic [lcd_pkg::AW-1:0]               paddr,                   // APB address
	input  wire logic [lcd_pkg::DW-1:0]               pwdata,                  // APB write data
	output logic      [lcd_pkg::DW-1:0]               prdata,                  // APB read data
	output logic                                      pready,                  // APB ready
	output logic                                      pslverr,                 // APB error
	input  wire logic [lcd_pkg::N_AN*lcd_pkg::VAL_W-1:0] monitored_value,      // Measured values
	input  wire logic [lcd_pkg::N_STAT-1:0]           status_in,               // Status signals
	output logic      [lcd_pkg::N_AN-1:0]             analog_cmp_out,          // Analogue outputs
	output logic      [lcd_pkg::N_AN-1:0]             analog_cmp_out_inverted, // Complements
	output logic      [lcd_pkg::N_DG-1:0]             digital_cmp_out,         // Digital outputs
	output logic      [lcd_pkg::N_ROUTE-1:0]          routed_out               // Relay/virtual
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] an_addr(input int idx, input logic [7:0] ofs);
		an_addr = lcd_pkg::AN_BASE + 8'(idx) * lcd_pkg::AN_STRIDE + ofs;
	endfunction

	function automatic logic [7:0] dg_addr(input int idx, input logic [7:0] ofs);
		dg_addr = lcd_pkg::DG_BASE + 8'(idx) * lcd_pkg::DG_STRIDE + ofs;
	endfunction

	// Advances an h:m:s.t word by one tenth, saturating at the top
	function automatic logic [lcd_pkg::DLY_W-1:0] tmr_inc(input logic [lcd_pkg::DLY_W-1:0] t);
		logic [9:0] ten;
		logic [5:0] mn;
		logic [3:0] hr;
		ten = t[lcd_pkg::TEN_LSB +: 10];
		mn  = t[lcd_pkg::MIN_LSB +: 6];
		hr  = t[lcd_pkg::HOUR_LSB +: 4];
		if (ten < lcd_pkg::TENTHS_MAX) begin
			ten = ten + 10'h001;
		end else if (mn < lcd_pkg::MIN_MAX) begin
			ten = 10'h000;
			mn  = mn + 6'h01;
		end else if (hr < lcd_pkg::HOUR_MAX) begin
			ten = 10'h000;
			mn  = 6'h00;
			hr  = hr + 4'h1;
		end
		tmr_inc = {hr, mn, ten};
	endfunction

	// ****************************************
	// Update tick divider
	// ****************************************
	logic [31:0] tick_cnt_ff, nxt_tick_cnt;
	logic        tick_ff, nxt_tick;

	always_comb begin
		nxt_tick     = 1'b0;
		nxt_tick_cnt = tick_cnt_ff + 32'h1;
		if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
			nxt_tick_cnt = 32'h0;
			nxt_tick     = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 32'h0;
			tick_ff     <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff     <= nxt_tick;
		end
	end

	// ****************************************
	// Settings registers
	// ****************************************
	logic [lcd_pkg::VAL_W-1:0] upper_ff [lcd_pkg::N_AN];
	logic [lcd_pkg::VAL_W-1:0] lower_ff [lcd_pkg::N_AN];
	logic                      type_ff  [lcd_pkg::N_AN];
	logic [lcd_pkg::SEL_W-1:0] sel_ff   [lcd_pkg::N_DG];
	logic [lcd_pkg::DLY_W-1:0] asd_ff   [lcd_pkg::N_CH];
	logic [lcd_pkg::DLY_W-1:0] rld_ff   [lcd_pkg::N_CH];
	logic [15:0]               route_ff;
	logic [lcd_pkg::VAL_W-1:0] nxt_upper [lcd_pkg::N_AN];
	logic [lcd_pkg::VAL_W-1:0] nxt_lower [lcd_pkg::N_AN];
	logic                      nxt_type  [lcd_pkg::N_AN];
	logic [lcd_pkg::SEL_W-1:0] nxt_sel   [lcd_pkg::N_DG];
	logic [lcd_pkg::DLY_W-1:0] nxt_asd   [lcd_pkg::N_CH];
	logic [lcd_pkg::DLY_W-1:0] nxt_rld   [lcd_pkg::N_CH];
	logic [15:0]               nxt_route;
	logic                      wr_en;

	assign wr_en = psel & penable & pready & pwrite;

	always_comb begin
		nxt_route = route_ff;
		if (wr_en && paddr == lcd_pkg::ROUTE_OFS) begin
			nxt_route = pwdata[15:0];
		end
		for (int i = 0; i < lcd_pkg::N_AN; i++) begin
			nxt_upper[i] = upper_ff[i];
			nxt_lower[i] = lower_ff[i];
			nxt_type[i]  = type_ff[i];
			nxt_asd[i]   = asd_ff[i];
			nxt_rld[i]   = rld_ff[i];
			if (wr_en) begin
				if (paddr == an_addr(i, lcd_pkg::AN_UPPER)) nxt_upper[i] = pwdata[15:0];
				if (paddr == an_addr(i, lcd_pkg::AN_LOWER)) nxt_lower[i] = pwdata[15:0];
				if (paddr == an_addr(i, lcd_pkg::AN_TYPE)) nxt_type[i] = pwdata[0];
				if (paddr == an_addr(i, lcd_pkg::AN_ASSERT)) nxt_asd[i] = pwdata[19:0];
				if (paddr == an_addr(i, lcd_pkg::AN_RELEASE)) nxt_rld[i] = pwdata[19:0];
			end
		end
		for (int j = 0; j < lcd_pkg::N_DG; j++) begin
			nxt_sel[j]               = sel_ff[j];
			nxt_asd[j + lcd_pkg::N_AN] = asd_ff[j + lcd_pkg::N_AN];
			nxt_rld[j + lcd_pkg::N_AN] = rld_ff[j + lcd_pkg::N_AN];
			if (wr_en) begin
				if (paddr == dg_addr(j, lcd_pkg::DG_SELECT)) nxt_sel[j] = pwdata[3:0];
				if (paddr == dg_addr(j, lcd_pkg::DG_ASSERT))
					nxt_asd[j + lcd_pkg::N_AN] = pwdata[19:0];
				if (paddr == dg_addr(j, lcd_pkg::DG_RELEASE))
					nxt_rld[j + lcd_pkg::N_AN] = pwdata[19:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			route_ff <= lcd_pkg::ROUTE_RST;
			for (int i = 0; i < lcd_pkg::N_AN; i++) begin
				upper_ff[i] <= lcd_pkg::UPPER_RST;
				lower_ff[i] <= lcd_pkg::LOWER_RST;
				type_ff[i]  <= lcd_pkg::TYPE_HYST;
			end
			for (int j = 0; j < lcd_pkg::N_DG; j++) begin
				sel_ff[j] <= lcd_pkg::SEL_RST[j*4 +: 4];
			end
			for (int k = 0; k < lcd_pkg::N_CH; k++) begin
				asd_ff[k] <= lcd_pkg::DLY_RST;
				rld_ff[k] <= lcd_pkg::DLY_RST;
			end
		end else begin
			route_ff <= nxt_route;
			upper_ff <= nxt_upper;
			lower_ff <= nxt_lower;
			type_ff  <= nxt_type;
			sel_ff   <= nxt_sel;
			asd_ff   <= nxt_asd;
			rld_ff   <= nxt_rld;
		end
	end

	// ****************************************
	// Raw comparisons
	// ****************************************
	logic [lcd_pkg::N_AN-1:0] hyst_ff, nxt_hyst;
	logic [lcd_pkg::N_CH-1:0] raw;

	always_comb begin
		for (int i = 0; i < lcd_pkg::N_AN; i++) begin
			logic signed [lcd_pkg::VAL_W-1:0] v;
			logic signed [lcd_pkg::VAL_W-1:0] hi;
			logic signed [lcd_pkg::VAL_W-1:0] lo;
			v  = monitored_value[i*lcd_pkg::VAL_W +: lcd_pkg::VAL_W];
			hi = upper_ff[i];
			lo = lower_ff[i];
			nxt_hyst[i] = hyst_ff[i];
			if (tick_ff) begin
				if (v > hi) begin
					nxt_hyst[i] = 1'b1;
				end else if (v < lo && lo <= hi) begin
					nxt_hyst[i] = 1'b0;
				end
			end
			if (type_ff[i] == lcd_pkg::TYPE_WIN) begin
				raw[i] = (v >= lo) && (v <= hi);
			end else begin
				raw[i] = nxt_hyst[i];
			end
		end
		for (int j = 0; j < lcd_pkg::N_DG; j++) begin
			raw[j + lcd_pkg::N_AN] = status_in[sel_ff[j]];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hyst_ff <= '0;
		end else begin
			hyst_ff <= nxt_hyst;
		end
	end

	// ****************************************
	// Assert and release delay stages
	// ****************************************
	logic [lcd_pkg::N_CH-1:0]  out_ff;
	logic [lcd_pkg::DLY_W-1:0] tmr_ff [lcd_pkg::N_CH];

	for (genvar g = 0; g < lcd_pkg::N_CH; g++) begin : g_dly
		logic                      nxt_out;
		logic [lcd_pkg::DLY_W-1:0] nxt_tmr;
		logic [lcd_pkg::SUB_W-1:0] sub_ff, nxt_sub;

		always_comb begin
			logic [lcd_pkg::DLY_W-1:0] dly;
			logic [lcd_pkg::SUB_W:0]   acc;
			dly     = raw[g] ? asd_ff[g] : rld_ff[g];
			acc     = {1'b0, sub_ff} + (lcd_pkg::SUB_W+1)'(lcd_pkg::TICK_MS);
			nxt_out = out_ff[g];
			nxt_tmr = tmr_ff[g];
			nxt_sub = sub_ff;
			if (tick_ff) begin
				if (raw[g] == out_ff[g]) begin
					nxt_tmr = '0;
					nxt_sub = '0;
				end else if (dly == lcd_pkg::DLY_RST) begin
					nxt_out = raw[g];
				end else begin
					if (acc >= (lcd_pkg::SUB_W+1)'(lcd_pkg::TENTH_MS)) begin
						acc     = acc - (lcd_pkg::SUB_W+1)'(lcd_pkg::TENTH_MS);
						nxt_tmr = tmr_inc(tmr_ff[g]);
					end
					nxt_sub = acc[lcd_pkg::SUB_W-1:0];
					if (nxt_tmr >= dly) begin
						nxt_out = raw[g];
						nxt_tmr = '0;
						nxt_sub = '0;
					end
				end
			end
		end

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				out_ff[g] <= 1'b0;
				tmr_ff[g] <= '0;
				sub_ff    <= '0;
			end else begin
				out_ff[g] <= nxt_out;
				tmr_ff[g] <= nxt_tmr;
				sub_ff    <= nxt_sub;
			end
		end
	end

	// ****************************************
	// Output pins
	// ****************************************
	logic [lcd_pkg::N_AN-1:0]    inv_ff;
	logic [lcd_pkg::N_ROUTE-1:0] route_out_ff, nxt_route_out;
	logic [15:0]                 src;

	always_comb begin
		src = {4'h0, out_ff[7:4], inv_ff, out_ff[3:0]};
		for (int r = 0; r < lcd_pkg::N_ROUTE; r++) begin
			nxt_route_out[r] = src[route_ff[r*4 +: 4]];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			route_out_ff <= '0;
		end else begin
			route_out_ff <= nxt_route_out;
		end
	end

	// Inverted copy driven from the same next value as the true output
	for (genvar a = 0; a < lcd_pkg::N_AN; a++) begin : g_inv
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				inv_ff[a] <= 1'b1;
			end else begin
				inv_ff[a] <= ~g_dly[a].nxt_out;
			end
		end
	end

	assign analog_cmp_out          = out_ff[3:0];
	assign analog_cmp_out_inverted = inv_ff;
	assign digital_cmp_out         = out_ff[7:4];
	assign routed_out              = route_out_ff;

	// ****************************************
	// APB read side
	// ****************************************
	logic [lcd_pkg::DW-1:0] prdata_ff, nxt_prdata;
	logic                   pready_ff, nxt_pready;
	logic                   pslverr_ff, nxt_pslverr;

	always_comb begin
		logic hit;
		hit         = 1'b0;
		nxt_prdata  = '0;
		nxt_pready  = psel & ~penable;
		if (paddr == lcd_pkg::ROUTE_OFS) begin
			hit        = 1'b1;
			nxt_prdata = {16'h0000, route_ff};
		end
		if (paddr == lcd_pkg::STATUS_OFS) begin
			hit        = 1'b1;
			nxt_prdata = {20'h00000, route_out_ff, out_ff};
		end
		for (int i = 0; i < lcd_pkg::N_AN; i++) begin
			case (paddr)
				an_addr(i, lcd_pkg::AN_UPPER): begin
					hit = 1'b1;
					nxt_prdata = {16'h0000, upper_ff[i]};
				end
				an_addr(i, lcd_pkg::AN_LOWER): begin
					hit = 1'b1;
					nxt_prdata = {16'h0000, lower_ff[i]};
				end
				an_addr(i, lcd_pkg::AN_TYPE): begin
					hit = 1'b1;
					nxt_prdata = {31'h0, type_ff[i]};
				end
				an_addr(i, lcd_pkg::AN_ASSERT): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, asd_ff[i]};
				end
				an_addr(i, lcd_pkg::AN_RELEASE): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, rld_ff[i]};
				end
				an_addr(i, lcd_pkg::AN_TIMER): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, tmr_ff[i]};
				end
				default: begin
				end
			endcase
		end
		for (int j = 0; j < lcd_pkg::N_DG; j++) begin
			case (paddr)
				dg_addr(j, lcd_pkg::DG_SELECT): begin
					hit = 1'b1;
					nxt_prdata = {28'h0, sel_ff[j]};
				end
				dg_addr(j, lcd_pkg::DG_ASSERT): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, asd_ff[j + lcd_pkg::N_AN]};
				end
				dg_addr(j, lcd_pkg::DG_RELEASE): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, rld_ff[j + lcd_pkg::N_AN]};
				end
				dg_addr(j, lcd_pkg::DG_TIMER): begin
					hit = 1'b1;
					nxt_prdata = {12'h000, tmr_ff[j + lcd_pkg::N_AN]};
				end
				default: begin
				end
			endcase
		end
		if (pwrite) begin
			nxt_prdata = '0;
		end
		nxt_pslverr = nxt_pready & ~hit;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
endmodule

// ===== inc/lcd_pkg.sv
/*
 * Constants for the level comparator and delay block: register map, field
 * layouts, reset values and timing counts.
 * Assumes a 125 MHz system clock and a 32-bit APB register bus.
 */
package lcd_pkg;
	// ****************************************
	// Widths and counts
	// ****************************************
	localparam int DW      = 32;
	localparam int AW      = 8;
	localparam int VAL_W   = 16;
	localparam int DLY_W   = 20;
	localparam int N_AN    = 4;
	localparam int N_DG    = 4;
	localparam int N_CH    = 8;
	localparam int N_STAT  = 16;
	localparam int SEL_W   = 4;
	localparam int N_ROUTE = 4;
	localparam int SUB_W   = 7;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] AN_BASE    = 8'h00;
	localparam logic [7:0] AN_STRIDE  = 8'h20;
	localparam logic [7:0] AN_UPPER   = 8'h00;
	localparam logic [7:0] AN_LOWER   = 8'h04;
	localparam logic [7:0] AN_TYPE    = 8'h08;
	localparam logic [7:0] AN_ASSERT  = 8'h0C;
	localparam logic [7:0] AN_RELEASE = 8'h10;
	localparam logic [7:0] AN_TIMER   = 8'h14;
	localparam logic [7:0] DG_BASE    = 8'h80;
	localparam logic [7:0] DG_STRIDE  = 8'h10;
	localparam logic [7:0] DG_SELECT  = 8'h00;
	localparam logic [7:0] DG_ASSERT  = 8'h04;
	localparam logic [7:0] DG_RELEASE = 8'h08;
	localparam logic [7:0] DG_TIMER   = 8'h0C;
	localparam logic [7:0] ROUTE_OFS  = 8'hC0;
	localparam logic [7:0] STATUS_OFS = 8'hC4;

	// ****************************************
	// Field codes and reset values
	// ****************************************
	localparam logic             TYPE_HYST = 1'b0;
	localparam logic             TYPE_WIN  = 1'b1;
	localparam logic [VAL_W-1:0] UPPER_RST = 16'h012C;
	localparam logic [VAL_W-1:0] LOWER_RST = 16'h00C8;
	localparam logic [DLY_W-1:0] DLY_RST   = 20'h00000;
	localparam logic [15:0]      SEL_RST   = 16'h3210;
	localparam logic [15:0]      ROUTE_RST = 16'hFFFF;
	localparam logic [3:0]       ROUTE_OFF = 4'hF;

	// ****************************************
	// Timer word layout: hours, minutes, tenths of seconds
	// ****************************************
	localparam int         TEN_LSB    = 0;
	localparam int         MIN_LSB    = 10;
	localparam int         HOUR_LSB   = 16;
	localparam logic [9:0] TENTHS_MAX = 10'h257;
	localparam logic [5:0] MIN_MAX    = 6'h3B;
	localparam logic [3:0] HOUR_MAX   = 4'h9;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ     = 125000;
	localparam int TICK_MS     = 8;
	localparam int TENTH_MS    = 100;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
endpackage

// ===== test/lcd_level_comparator_delay_monitor.sv
/*
 * Checker for the level comparator block: bus handshake, tick spacing of output
 * changes, complement output and routing lag.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns

module lcd_level_comparator_delay_monitor #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic        mclk,                    // Clock
	input wire logic        rst_n,                   // Reset
	input wire logic        psel,                    // Select
	input wire logic        penable,                 // Enable
	input wire logic        pwrite,                  // Direction
	input wire logic [7:0]  paddr,                   // Address
	input wire logic [31:0] pwdata,                  // Write data
	input wire logic [31:0] prdata,                  // Read data
	input wire logic        pready,                  // Ready
	input wire logic        pslverr,                 // Error
	input wire logic [63:0] monitored_value,         // Values
	input wire logic [15:0] status_in,               // Status
	input wire logic [3:0]  analog_cmp_out,          // Analogue
	input wire logic [3:0]  analog_cmp_out_inverted, // Complement
	input wire logic [3:0]  digital_cmp_out,         // Digital
	input wire logic [3:0]  routed_out               // Routed
);
	// ****************************************
	// Cycles since the last output change
	// ****************************************
	logic [7:0]  outs_ff;
	logic [31:0] gap_ff;
	logic [31:0] nxt_gap;
	always_comb begin
		nxt_gap = gap_ff + 32'h1;
		if ({analog_cmp_out, digital_cmp_out} != outs_ff)
			nxt_gap = 32'h0;
		else if (gap_ff == 32'hFFFF)
			nxt_gap = gap_ff;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outs_ff <= 8'h00;
			gap_ff  <= 32'h0;
		end else begin
			outs_ff <= {analog_cmp_out, digital_cmp_out};
			gap_ff  <= nxt_gap;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence

	AST_INV_COMPL: assert property (analog_cmp_out_inverted == ~analog_cmp_out)
		else $error("inverted output is not the complement");
	AST_TICK_SPACING: assert property (({analog_cmp_out, digital_cmp_out} != outs_ff)
		|-> gap_ff >= TICK_CYCLES - 1)
		else $error("outputs changed between update ticks");
	AST_READY_AFTER_SETUP: assert property (s_setup |=> pready)
		else $error("no ready after setup cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside an access cycle");
	AST_READY_SINGLE: assert property (s_setup ##1 s_access |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_ERR_ZERO_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	AST_WRITE_RDATA_ZERO: assert property (s_access and (pwrite && pready) |-> prdata == 32'h0)
		else $error("read data not zero on a write");
	AST_ROUTE_LAG: assert property ($changed(routed_out) |->
		$past({analog_cmp_out, digital_cmp_out}) != $past(outs_ff)
		|| $past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("routed output changed without cause");
endmodule

bind lcd_level_comparator_delay lcd_level_comparator_delay_monitor #(
	.TICK_CYCLES(TICK_CYCLES)
) u_mon (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.monitored_value(monitored_value), .status_in(status_in), .analog_cmp_out(analog_cmp_out),
	.analog_cmp_out_inverted(analog_cmp_out_inverted), .digital_cmp_out(digital_cmp_out),
	.routed_out(routed_out));

// ===== test/lcd_level_comparator_delay_tb_top.sv
/*
 * Self-checking bench for the level comparator block, driving APB and inputs.
 * Assumes a shortened update tick of 20 clock cycles.
 */
`timescale 1ns/1ns

module lcd_level_comparator_delay_tb_top;
	localparam int TICK = 20;
	localparam logic [63:0] VALS [6] = '{64'hFF9C_00FA_00C7_00FA, 64'hFF9C_012D_00C8_012D,
		64'hFF9C_0064_012C_00FA, 64'hFF9C_0000_012D_00C7, 64'hFF9C_FF9C_0096_012C,
		64'hFF9C_FF9C_00FA_012D};
	localparam logic [3:0] EXPS [6] = '{4'h0, 4'h7, 4'h7, 4'h4, 4'h4, 4'h7};

	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, errv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [63:0] mv;
	logic [15:0] stat;
	logic [3:0]  an, an_n, dg, ro;
	int          fail_count, checked, cyc;

	lcd_level_comparator_delay #(.TICK_CYCLES(TICK)) uut (.mclk(mclk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .monitored_value(mv),
		.status_in(stat), .analog_cmp_out(an), .analog_cmp_out_inverted(an_n),
		.digital_cmp_out(dg), .routed_out(ro));

	always #4 mclk = ~mclk;

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50)
			fail_count++;
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask

	task ticks(input int n);
		repeat (n * TICK) @(posedge mclk);
	endtask

	function automatic logic [7:0] ana(input int i, input logic [7:0] o);
		return lcd_pkg::AN_BASE + lcd_pkg::AN_STRIDE * 8'(i) + o;
	endfunction

	function automatic logic [7:0] dig(input int i, input logic [7:0] o);
		return lcd_pkg::DG_BASE + lcd_pkg::DG_STRIDE * 8'(i) + o;
	endfunction

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count++;
			finish_test;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		mclk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; mv = 64'h0; stat = 16'h0;
		fail_count = 0; checked = 0; cyc = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		chk({28'h0, an_n}, 32'h0000000F);
		for (int i = 0; i < 4; i++) begin
			rd(ana(i, lcd_pkg::AN_UPPER), 32'h0000012C);
			rd(ana(i, lcd_pkg::AN_LOWER), 32'h000000C8);
			rd(ana(i, lcd_pkg::AN_TYPE), 32'h0);
			rd(ana(i, lcd_pkg::AN_ASSERT), 32'h0);
			rd(ana(i, lcd_pkg::AN_RELEASE), 32'h0);
			rd(dig(i, lcd_pkg::DG_SELECT), 32'(i));
			rd(dig(i, lcd_pkg::DG_ASSERT), 32'h0);
			rd(dig(i, lcd_pkg::DG_RELEASE), 32'h0);
		end
		rd(lcd_pkg::ROUTE_OFS, 32'h0000FFFF);
		rd(8'h18, 32'h0);
		chk({31'h0, errv}, 32'h1);
		apb(1'b1, 8'hC8, 32'h1);
		chk({31'h0, errv}, 32'h1);
		apb(1'b1, ana(0, lcd_pkg::AN_TIMER), 32'h5);
		rd(ana(0, lcd_pkg::AN_TIMER), 32'h0);
		// Comparator 1 window, comparator 2 latching, comparator 3 negative input
		apb(1'b1, ana(1, lcd_pkg::AN_TYPE), 32'h1);
		apb(1'b1, ana(2, lcd_pkg::AN_LOWER), 32'h00000190);
		for (int s = 0; s < 6; s++) begin
			mv <= VALS[s];
			ticks(3);
			chk({28'h0, an}, {28'h0, EXPS[s]});
			chk({28'h0, an_n}, {28'h0, ~EXPS[s]});
		end
		// Release delay with a restart, then expiry
		apb(1'b1, ana(0, lcd_pkg::AN_RELEASE), 32'h5);
		mv[15:0] <= 16'h0000;
		ticks(40);
		chk({31'h0, an[0]}, 32'h1);
		rd(ana(0, lcd_pkg::AN_TIMER), 32'h3);
		mv[15:0] <= 16'h012D;
		ticks(3);
		rd(ana(0, lcd_pkg::AN_TIMER), 32'h0);
		mv[15:0] <= 16'h0000;
		ticks(70);
		chk({31'h0, an[0]}, 32'h0);
		// Assert delay
		apb(1'b1, ana(0, lcd_pkg::AN_ASSERT), 32'h5);
		mv[15:0] <= 16'h012D;
		ticks(40);
		chk({31'h0, an[0]}, 32'h0);
		rd(ana(0, lcd_pkg::AN_TIMER), 32'h3);
		ticks(30);
		chk({31'h0, an[0]}, 32'h1);
		// Digital comparators
		stat <= 16'h0001;
		ticks(3);
		chk({28'h0, dg}, 32'h1);
		apb(1'b1, dig(1, lcd_pkg::DG_SELECT), 32'h5);
		stat <= 16'h0020;
		ticks(3);
		chk({28'h0, dg}, 32'h2);
		apb(1'b1, dig(1, lcd_pkg::DG_RELEASE), 32'h3);
		stat <= 16'h0000;
		ticks(30);
		chk({28'h0, dg}, 32'h2);
		rd(dig(1, lcd_pkg::DG_TIMER), 32'h2);
		ticks(15);
		chk({28'h0, dg}, 32'h0);
		apb(1'b1, dig(2, lcd_pkg::DG_ASSERT), 32'h1);
		stat <= 16'h0004;
		ticks(8);
		chk({28'h0, dg}, 32'h0);
		ticks(10);
		chk({28'h0, dg}, 32'h4);
		// Routing: analogue 0, inverted 0, digital 2, constant
		apb(1'b1, lcd_pkg::ROUTE_OFS, 32'h0000FA40);
		ticks(1);
		chk({28'h0, ro}, 32'h5);
		rd(lcd_pkg::STATUS_OFS, 32'h00000547);
		finish_test;
	end
endmodule
